// ### irq_ctrl_map.vh
// register map, field positions, reset values and timing counts of the interrupt controller
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

// apb byte offsets, one aligned word each
`define PRIMARY_EN_OFS   12'h000
`define EXT_EN_ONE_OFS   12'h004
`define EXT_EN_TWO_OFS   12'h008
`define PRIORITY_OFS     12'h00c
`define PEND_SET_OFS     12'h010
`define PEND_CLR_OFS     12'h014
`define STATUS_OFS       12'h018

// field positions
`define GLOBAL_EN_BIT    7
`define PRIMARY_SRC_CNT  7
`define EXT_ONE_SRC_CNT  8
`define EXT_TWO_SRC_CNT  2

// reset values
`define ENABLE_RST       8'h00
`define PRIORITY_RST     32'h0000_0000
`define PENDING_RST      32'h0000_0000

// vector table: base address and spacing between vectors
`define VEC_BASE         16'h0003
`define VEC_STEP         16'h0008

// timing counts in system clock cycles
`define DETECT_CYCLES    1
`define CALL_CYCLES      3'h5

`endif

// ### irq_ctrl.v
// two-level interrupt controller with apb register access and core sequencing handshake
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.vh"

// interface summary:
// - apb answers every transfer with exactly one access cycle, no extra waits
// - read data is captured in the setup cycle and stands with pready
// - src_event bits need no synchroniser, the sources run on this same clock
// - a request reaches irq_req two cycles after its flag is set
// - irq_take pulses one cycle after the accepting instruction boundary,
//   and irq_call_busy then stands for the five cycles of the long_call
// - irq_vector and irq_level_hi hold until the next accepted request
// - clk_en low freezes every register, the apb answer included
// - limitation: at most 17 sources, the width of the three enable registers

module irq_ctrl #(
    parameter        N_SRC   = 17,               // number of sources, at most 17
    parameter [31:0] AUTOCLR = 32'h0000_000f     // flags cleared by hardware on vectoring
) (
    input  wire        pclk,            // system clock
    input  wire        presetn,         // asynchronous reset, active low
    input  wire        clk_en,          // freezes all state while low
    input  wire        psel,            // apb select
    input  wire        penable,         // apb access phase
    input  wire        pwrite,          // apb direction
    input  wire [11:0] paddr,           // apb byte address
    input  wire [31:0] pwdata,          // apb write data
    output reg  [31:0] prdata,          // apb read data
    output reg         pready,          // apb ready
    output reg         pslverr,         // apb error on unmapped address
    input  wire [N_SRC-1:0] src_event,  // one-cycle valid interrupt conditions
    input  wire        instr_boundary,  // core finishes an instruction this cycle
    input  wire        next_multi,      // the following instruction is multi-cycle
    input  wire        return_done,     // core completed return_from_interrupt
    output reg         irq_req,         // request toward the core
    output reg         irq_take,        // pulse: request accepted, long_call starts
    output reg         irq_call_busy,   // long_call in progress
    output reg  [15:0] irq_vector,      // vector of the accepted source
    output reg         irq_level_hi,    // accepted request is high priority
    output reg  [1:0]  in_service       // bit1 high, bit0 low level routine running
);

    localparam IW = 5;                         // source index width
    // reset images as full words, cut to the source count where they are used
    localparam [31:0] PRIO_RST_W = `PRIORITY_RST;   // all sources low level
    localparam [31:0] PEND_RST_W = `PENDING_RST;    // nothing pending

    // register state
    // every flop below is frozen by clk_en and cleared by presetn
    reg [7:0]       primary_irq_enable_reg_r;  // bit7 global, bits 6:0 sources 0..6
    reg [7:0]       extended_enable_reg_one_r; // sources 7..14
    reg [7:0]       extended_enable_reg_two_r; // sources 15..16
    reg [N_SRC-1:0] prio_r;                    // one = high level
    reg [N_SRC-1:0] pend_r;                    // pending flags
    reg             req_r;                     // registered request
    reg [IW-1:0]    sel_r;                     // registered winner index
    reg             sel_hi_r;                  // registered winner level
    reg             ret_block_r;               // one instruction must run after return
    reg [2:0]       call_cnt_r;                // long_call cycle counter
    reg [1:0]       insvc_r;                   // running levels

    // combinational helpers
    // these settle within the cycle and are never read as state
    reg  [N_SRC-1:0] pend_nxt;
    reg  [N_SRC-1:0] auto_clr;
    reg  [N_SRC-1:0] sw_set;
    reg  [N_SRC-1:0] sw_clr;
    reg  [IW-1:0]    win_idx;
    reg              win_hi;
    reg              win_any;
    reg  [31:0]      rd_data;
    reg              rd_hit;
    integer          i;

    // the three enable registers pack into one vector, source 0 at bit 0
    wire [16:0] en_all = {extended_enable_reg_two_r[`EXT_TWO_SRC_CNT-1:0],
                          extended_enable_reg_one_r,
                          primary_irq_enable_reg_r[`PRIMARY_SRC_CNT-1:0]};
    wire global_irq_enable = primary_irq_enable_reg_r[`GLOBAL_EN_BIT];
    // global gate over individual enables
    wire [N_SRC-1:0] live = pend_r & en_all[N_SRC-1:0]
                            & {N_SRC{global_irq_enable}};

    wire apb_acc = psel & penable & pready;    // transfer completes this edge
    wire apb_wr  = apb_acc & pwrite;
    wire call_go = (call_cnt_r != 3'h0);

    // a winner may start only if nothing runs, or it is high and only low runs
    wire level_ok = (insvc_r == 2'b00) | (sel_hi_r & ~insvc_r[1]);
    // a stale request from a just-cleared enable survives only before a short instruction
    wire late_ok  = win_any | ~next_multi;
    // a call in progress or a pending return block holds off every take
    wire take_now = instr_boundary & req_r & level_ok & late_ok
                    & ~ret_block_r & ~call_go;

    // priority decode: high level beats low, lower index wins within a level
    // the loops run downwards so the last hit, the lowest index, is kept;
    // the high loop runs second and overrides any low winner
    always @* begin
        win_idx = {IW{1'b0}};
        win_hi  = 1'b0;
        win_any = 1'b0;
        for (i = N_SRC - 1; i >= 0; i = i - 1) begin
            if (live[i] && !prio_r[i] && !win_hi) begin
                win_idx = i[IW-1:0];
                win_any = 1'b1;
            end
        end
        for (i = N_SRC - 1; i >= 0; i = i - 1) begin
            if (live[i] && prio_r[i]) begin
                win_idx = i[IW-1:0];
                win_hi  = 1'b1;
                win_any = 1'b1;
            end
        end
    end

    // pending flag next state; a set always wins over any clear in the same cycle
    // software write-one-to-clear and the hardware clear on vectoring share one path,
    // so a condition arriving while the flag is cleared is never lost
    always @* begin
        sw_set   = {N_SRC{1'b0}};
        sw_clr   = {N_SRC{1'b0}};
        auto_clr = {N_SRC{1'b0}};
        if (apb_wr && paddr == `PEND_SET_OFS) begin
            sw_set = pwdata[N_SRC-1:0];
        end
        if (apb_wr && paddr == `PEND_CLR_OFS) begin
            sw_clr = pwdata[N_SRC-1:0];
        end
        if (take_now) begin
            auto_clr[sel_r] = AUTOCLR[sel_r];
        end
        // hardware sets ignore enables entirely
        pend_nxt = (pend_r & ~(sw_clr | auto_clr)) | src_event | sw_set;
    end

    // read mux; unmapped addresses answer with an error
    // both pending offsets read the same flags, so software can check a set or clear
    // status bit 1 is spare and reads zero
    always @* begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (paddr)
            `PRIMARY_EN_OFS: rd_data[7:0] = primary_irq_enable_reg_r;
            `EXT_EN_ONE_OFS: rd_data[7:0] = extended_enable_reg_one_r;
            `EXT_EN_TWO_OFS: rd_data[7:0] = extended_enable_reg_two_r;
            `PRIORITY_OFS:   rd_data[N_SRC-1:0] = prio_r;
            `PEND_SET_OFS:   rd_data[N_SRC-1:0] = pend_r;
            `PEND_CLR_OFS:   rd_data[N_SRC-1:0] = pend_r;
            `STATUS_OFS:     rd_data[12:0] = {insvc_r, sel_hi_r, sel_r, call_go,
                                              ret_block_r, req_r, 1'b0, global_irq_enable};
            default:         rd_hit = 1'b0;
        endcase
    end

    // apb slave: ready one cycle after setup, data and error registered with it
    // trade-off: read data is taken at setup, so a flag set in the access cycle
    // shows on the next read rather than this one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_hit;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_data;
            end
        end
    end

    // software-visible registers; enables clear to zero so nothing fires early
    // an enable cleared here stops new winners at once; a request already in the
    // detection stage may still be taken before a single-cycle instruction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_irq_enable_reg_r  <= `ENABLE_RST;
            extended_enable_reg_one_r <= `ENABLE_RST;
            extended_enable_reg_two_r <= `ENABLE_RST;
            prio_r                    <= PRIO_RST_W[N_SRC-1:0]; // low is the default
            pend_r                    <= PEND_RST_W[N_SRC-1:0];
        end else if (clk_en) begin
            pend_r <= pend_nxt;
            if (apb_wr) begin
                case (paddr)
                    `PRIMARY_EN_OFS: primary_irq_enable_reg_r  <= pwdata[7:0];
                    `EXT_EN_ONE_OFS: extended_enable_reg_one_r <= pwdata[7:0];
                    `EXT_EN_TWO_OFS: extended_enable_reg_two_r <= pwdata[7:0];
                    `PRIORITY_OFS:   prio_r <= pwdata[N_SRC-1:0];
                    default: ;
                endcase
            end
        end
    end

    // detection stage: the request is sampled and decoded every cycle, one cycle late
    // the registered winner is what gets vectored, so the decode and the take never
    // disagree even when a flag changes in the take cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r    <= 1'b0;
            sel_r    <= {IW{1'b0}};
            sel_hi_r <= 1'b0;
        end else if (clk_en) begin
            req_r <= win_any;
            // keep the last winner while a stale request may still be taken
            if (win_any) begin
                sel_r    <= win_idx;
                sel_hi_r <= win_hi;
            end
        end
    end

    // sequencing: in-service levels, long_call timing and the post-return block
    // the block after a return makes one instruction run before any re-entry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insvc_r     <= 2'b00;
            call_cnt_r  <= 3'h0;
            ret_block_r <= 1'b0;
        end else if (clk_en) begin
            // long_call occupies a fixed number of cycles
            if (take_now) begin
                call_cnt_r <= `CALL_CYCLES;
            end else if (call_go) begin
                call_cnt_r <= call_cnt_r - 3'h1;
            end
            // return pops the most recent level, then one instruction must run
            if (return_done) begin
                ret_block_r <= 1'b1;
            end else if (instr_boundary) begin
                ret_block_r <= 1'b0;
            end
            // the return pops first so that a take in the same cycle is not lost
            if (return_done) begin
                if (insvc_r[1]) begin
                    insvc_r[1] <= 1'b0;          // high level ends first
                end else begin
                    insvc_r[0] <= 1'b0;          // otherwise the low level ends
                end
            end
            // a take marks its level; the later assignment wins on a shared bit
            if (take_now) begin
                if (sel_hi_r) begin
                    insvc_r[1] <= 1'b1;
                end else begin
                    insvc_r[0] <= 1'b1;
                end
            end
        end
    end

    // core-facing outputs, all registered
    // registering costs one cycle on every core signal but keeps them glitch free
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req       <= 1'b0;
            irq_take      <= 1'b0;
            irq_call_busy <= 1'b0;
            irq_vector    <= 16'h0000;
            irq_level_hi  <= 1'b0;
            in_service    <= 2'b00;
        end else if (clk_en) begin
            irq_req       <= req_r & level_ok;
            irq_take      <= take_now;
            irq_call_busy <= take_now | (call_cnt_r > 3'h1);
            in_service    <= insvc_r;
            if (take_now) begin
                // fixed vector per source, evenly spaced
                // the spacing is a power of two, so a shift replaces a table
                irq_vector   <= `VEC_BASE + ({11'h000, sel_r} << 3);
                irq_level_hi <= sel_hi_r;
            end
        end
    end

endmodule // irq_ctrl

`default_nettype wire

// ### irq_ctrl_checker.sv
// port-level assertion checker for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire        instr_boundary,
    input wire        return_done,
    input wire        irq_req,
    input wire        irq_take,
    input wire        irq_call_busy,
    input wire [15:0] irq_vector,
    input wire        irq_level_hi,
    input wire [1:0]  in_service
);
    // one clock domain, so one clocking and one reset for all
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_apb_ready: assert property (psel && penable |-> pready ##1 !pready)
        else $error("apb access not answered in one cycle");
    a_take_pulse: assert property (irq_take |-> irq_call_busy ##1 !irq_take)
        else $error("take is not a single pulse");
    a_call_len: assert property ($rose(irq_call_busy) |->
        irq_call_busy[*5] ##1 !irq_call_busy)
        else $error("call phase not five cycles");
    a_vec_align: assert property (irq_take |->
        irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0083)
        else $error("vector off the table");
    a_hi_no_preempt: assert property (in_service[1] |-> !irq_take)
        else $error("high routine preempted");
    a_ret_one_instr: assert property (return_done ##1 instr_boundary |=> !irq_take)
        else $error("no instruction ran after return");
    a_level_service: assert property (irq_take |=>
        (irq_level_hi ? in_service[1] : in_service[0]))
        else $error("service level mismatch");
    a_reset_quiet: assert property ($rose(presetn) |-> !irq_req && !irq_take)
        else $error("request right after reset");
endmodule // irq_ctrl_checker

bind irq_ctrl irq_ctrl_checker i_irq_ctrl_checker (.pclk, .presetn, .psel, .penable,
    .pready, .instr_boundary, .return_done, .irq_req, .irq_take, .irq_call_busy,
    .irq_vector, .irq_level_hi, .in_service);
`default_nettype wire

// ### core_model.sv
// behavioural core sequencer facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic pclk,           // system clock
    input  wire logic presetn,        // reset, active low
    input  wire logic irq_call_busy,  // long call running, core stalls
    input  wire logic do_ret,         // routine wants to return
    input  wire logic stall,          // holds off instruction ends
    output var  logic instr_boundary, // an instruction ends
    output var  logic return_done     // return instruction finished
);
    // two-cycle instructions; no boundary while the call runs or a return ends
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_boundary <= 1'b0;
            return_done    <= 1'b0;
        end else begin
            return_done    <= do_ret;
            instr_boundary <= !instr_boundary && !irq_call_busy && !do_ret && !stall;
        end
    end
endmodule // core_model
`default_nettype wire

// ### tb_top.sv
// self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.vh"
module tb_top;
    logic        pclk = 0, presetn = 0;         // clock and reset
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [16:0] src_event = 0;                 // source conditions
    logic        next_multi = 0, do_ret = 0, er, stall = 0; // stall holds off instruction ends
    wire  [31:0] prdata;
    wire         pready, pslverr, irq_req, irq_take, irq_call_busy, irq_level_hi;
    wire         instr_boundary, return_done;
    wire  [15:0] irq_vector;
    wire  [1:0]  in_service;
    int          errors = 0, comparisons = 0;

    always #25 pclk = ~pclk;

    irq_ctrl i_irq_ctrl (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .src_event, .instr_boundary,
        .next_multi, .return_done, .irq_req, .irq_take, .irq_call_busy, .irq_vector,
        .irq_level_hi, .in_service);
    core_model i_core_model (.pclk, .presetn, .irq_call_busy, .do_ret, .stall,
        .instr_boundary, .return_done);

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) begin
            errors++;
            $display("CHECK FAILED pready expected 1 seen %b", pready);
        end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(nm, exp, rd);
    endtask
    task pulse(input int i);
        @(posedge pclk);
        src_event[i] <= 1;
        @(posedge pclk);
        src_event <= 0;
    endtask
    // bounded wait for an accepted request, then check where it went
    task wait_take(input logic [15:0] vec, input logic hi);
        int n;
        n = 0;
        do @(posedge pclk); while (irq_take !== 1'b1 && ++n < 60);
        chk("take", 1, irq_take);
        chk("vector", vec, irq_vector);
        chk("level", hi, irq_level_hi);
    endtask
    // the call lasts five cycles, so the routine returns after it
    task ret;
        repeat (6) @(posedge pclk);
        do_ret <= 1;
        @(posedge pclk);
        do_ret <= 0;
    endtask
    // source 4 posts while its enable is cleared; the core ends an instruction
    // exactly one cycle after the clearing write lands
    task late(input logic multi);
        wr(`PRIMARY_EN_OFS, 32'h90);
        stall <= 1;
        next_multi <= multi;
        fork
            wr(`PRIMARY_EN_OFS, 32'h80);
            pulse(4);
            begin
                repeat (2) @(posedge pclk);
                stall <= 0;
            end
        join
    endtask

    task end_of_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog: the sequence needs far fewer cycles than this
    initial begin
        #200000;
        errors++;
        end_of_test;
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        for (int a = 0; a <= 'h18; a += 4) rdc("reset reg", a[11:0], 0);
        apb(0, 12'h01c, 0);
        chk("unmapped", 1, er);
        pulse(5);
        rdc("pending", `PEND_SET_OFS, 32'h20);
        chk("req disabled", 0, irq_req);
        wr(`PRIMARY_EN_OFS, 32'h20);
        repeat (4) @(posedge pclk);
        chk("req no global", 0, irq_req);
        wr(`PRIMARY_EN_OFS, 32'ha0);
        wait_take(16'h002b, 0);
        rdc("flag kept", `PEND_SET_OFS, 32'h20);
        ret;
        wait_take(16'h002b, 0);
        wr(`PEND_CLR_OFS, 32'h20);
        ret;
        wr(`EXT_EN_ONE_OFS, 32'h01);
        wr(`PEND_SET_OFS, 32'h80);
        wait_take(16'h003b, 0);
        wr(`PEND_CLR_OFS, 32'h80);
        ret;
        wr(`PRIMARY_EN_OFS, 32'h88);
        pulse(3);
        wait_take(16'h001b, 0);
        rdc("auto clear", `PEND_SET_OFS, 0);
        ret;
        // two flags at once, the higher index at high priority
        wr(`PRIORITY_OFS, 32'h40);
        wr(`PRIMARY_EN_OFS, 32'hc2);
        wr(`PEND_SET_OFS, 32'h42);
        wait_take(16'h0033, 1);
        wr(`PEND_CLR_OFS, 32'h40);
        ret;
        wait_take(16'h000b, 0);
        wr(`PEND_SET_OFS, 32'h40);
        wait_take(16'h0033, 1);
        wr(`PEND_CLR_OFS, 32'h42);
        ret;
        ret;
        // late request before a single-cycle instruction is still taken
        late(0);
        wait_take(16'h0023, 0);
        rdc("late enable", `PRIMARY_EN_OFS, 32'h80);
        wr(`PEND_CLR_OFS, 32'h10);
        ret;
        // the clear followed by a multi-cycle instruction drops it
        late(1);
        repeat (10) @(posedge pclk);
        chk("late multi", 0, in_service);
        rdc("late flag", `PEND_SET_OFS, 32'h10);
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
